// [sensor_queue_pkg.sv]
package sensor_queue_pkg;

    // ==========================================================
    // register offsets on the serial access port
    localparam logic [6:0] SERIAL_INTERFACE_SELECT = 7'h70;
    localparam logic [6:0] QUEUE_LEVEL_HIGH        = 7'h72;
    localparam logic [6:0] QUEUE_LEVEL_LOW         = 7'h73;
    localparam logic [6:0] QUEUE_DATA_WINDOW       = 7'h74;
    localparam logic [6:0] PART_IDENTITY           = 7'h75;
    localparam logic [6:0] X_ACCEL_OFFSET_UPPER    = 7'h77;
    localparam logic [6:0] X_ACCEL_OFFSET_LOWER    = 7'h78;
    localparam logic [6:0] Y_ACCEL_OFFSET_UPPER    = 7'h7a;
    localparam logic [6:0] Y_ACCEL_OFFSET_LOWER    = 7'h7b;
    localparam logic [6:0] Z_ACCEL_OFFSET_UPPER    = 7'h7d;
    localparam logic [6:0] Z_ACCEL_OFFSET_LOWER    = 7'h7e;

    // ==========================================================
    // fields and fixed values
    localparam int         SERIAL_TARGET_DISABLE_BIT = 6;
    localparam logic [7:0] QUEUE_EMPTY_MARK          = 8'hff;
    localparam logic [7:0] QUEUE_DATA_CLAMP          = 8'hfe;
    localparam logic [6:0] I2C_TARGET_BASE           = 7'h68;
    localparam int         OFFSET_BITS               = 15;
    localparam int         OFFSET_LOW_BITS           = 7;
    localparam int         COUNT_BITS                = 16;
    // offset step is fixed near 1 mg; raw scale at +-2 g is 16x finer
    localparam logic [2:0] OFFSET_SHIFT_AT_2G        = 3'h4;

    // ==========================================================
    // sensor bytes loaded per sample tick, lowest register first
    localparam int         SENSOR_BYTES  = 14;
    localparam int         ACCEL_BYTES   = 6;
    localparam int         BYTE_IDX_BITS = 4;
    localparam logic [2:0] ACCEL_EN_BIT  = 3'h3;
    localparam logic [2:0] TEMP_EN_BIT   = 3'h7;
    localparam logic [2:0] GYRO_X_EN_BIT = 3'h6;
    localparam logic [2:0] GYRO_Y_EN_BIT = 3'h5;
    localparam logic [2:0] GYRO_Z_EN_BIT = 3'h4;

    // ==========================================================
    // sample loader states
    typedef enum logic [1:0] {
        LOAD_IDLE = 2'b01,
        LOAD_SCAN = 2'b10
    } load_state_t;

endpackage

// [sensor_queue_regs.sv]
// Operation
// - writing one to bit 6 at 0x70 turns off I2C target, SPI only
// - queued byte count reported as 16 bits: high at 0x72, low at 0x73
// - reading the high count byte captures current count into both halves
// - reading the low count byte latches a fresh count pair
// - data port at 0x74: read pops next byte, write pushes a byte
// - a sample tick taken while the loader is idle loads enabled sensor bytes in ascending register order
// - a sensor's bytes enter the queue only while its source flag is set
// - queue overflow raises the overrun flag
// - overflow drops oldest bytes, or keeps stored data when stop-when-full set
// - empty queue reads return 0xff until a new byte is stored
// - no genuine queued byte ever takes the value 0xff
// - read-only identity register at 0x75 returns a fixed code
// - I2C address 0x68 or 0x69 by select pin, distinct from identity
// - 15-bit axis offsets: bits 14..7 upper, bits 6..0 in lower bits 7..1
// - offset step about 0.98 mg, +-16 g range at every full scale
// - queue reset request clears the queue within one cycle
// - queue runs only while enabled; otherwise serial queue access is off
module sensor_queue_regs
    import sensor_queue_pkg::*;
#(
    parameter int         DEPTH         = 1024,
    parameter logic [7:0] IDENTITY_CODE = 8'h5a  // arbitrary value
) (
    input  wire logic                                 clk_i,
    input  wire logic                                 reset_i,
    input  wire logic                                 reg_write_i,
    input  wire logic                                 reg_read_i,
    input  wire logic [6:0]                           reg_addr_i,
    input  wire logic [7:0]                           reg_wdata_i,
    input  wire logic                                 via_i2c_i,
    input  wire logic [6:0]                           i2c_target_addr_i,
    input  wire logic                                 address_select_pin_i,
    input  wire logic                                 sample_tick_i,
    input  wire logic [7:0]                           queue_source_enable_i,
    input  wire logic                                 queue_enable_i,
    input  wire logic                                 queue_reset_i,
    input  wire logic                                 stop_when_full_i,
    input  wire logic [1:0]                           accel_full_scale_i,
    input  wire logic [3*16-1:0]                      accel_raw_i,
    input  wire logic [8*(sensor_queue_pkg::SENSOR_BYTES-sensor_queue_pkg::ACCEL_BYTES)-1:0] other_sensor_bytes_i,
    output logic      [7:0]                           reg_rdata_o,
    output logic                                      serial_target_disable_o,
    output logic      [6:0]                           i2c_target_addr_o,
    output logic      [3*16-1:0]                      accel_corrected_o,
    output logic                                      queue_overrun_flag_o
);
    import sensor_queue_pkg::*;

    // at least one pointer bit so a single-entry queue still elaborates
    localparam int PTR_BITS = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // all registers of the block in one struct, filled by one process
    typedef struct packed {
        logic [DEPTH-1:0][7:0]          mem;
        logic [PTR_BITS-1:0]            wr_ptr;
        logic [PTR_BITS-1:0]            rd_ptr;
        logic [COUNT_BITS-1:0]          count;
        logic [COUNT_BITS-1:0]          held_count;
        logic                           target_disable;
        logic [2:0][OFFSET_BITS-1:0]    offset;
        logic [7:0]                     rdata;
        logic [BYTE_IDX_BITS-1:0]       load_idx;
        load_state_t                    load_state;
        logic                           overrun;
        logic [2:0][15:0]               accel_out;
    } state_t;

    // present state and the value it takes at the next edge
    state_t state;
    state_t next_state;

    // ==========================================================
    // offset cancellation per axis
    logic [SENSOR_BYTES-1:0][7:0] sensor_byte;
    logic [2:0][15:0]             accel_fixed;

    // one lane per axis, then one slot per sensor byte
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_axis
            logic signed [19:0] raw_ext;
            logic signed [19:0] off_ext;
            logic signed [19:0] off_scaled;
            logic signed [19:0] diff;
            logic        [2:0]  shift;
            assign raw_ext = 20'($signed(accel_raw_i[g*16 +: 16]));
            assign off_ext = 20'($signed(state.offset[g]));
            // same cancellation range in g at every full scale
            assign shift      = OFFSET_SHIFT_AT_2G - {1'b0, accel_full_scale_i};
            assign off_scaled = off_ext <<< shift;
            assign diff       = raw_ext - off_scaled;
            // saturate instead of wrapping so a large offset cannot flip sign
            assign accel_fixed[g] = (diff > 20'sd32767)  ? 16'h7fff :
                                    (diff < -20'sd32768) ? 16'h8000 : diff[15:0];
        end
        // accel bytes come from the registered, corrected axes, high byte first
        for (g = 0; g < SENSOR_BYTES; g++) begin : g_byte
            if (g < ACCEL_BYTES && g % 2 == 0) begin : g_hi
                assign sensor_byte[g] = state.accel_out[g/2][15:8];
            end else if (g < ACCEL_BYTES) begin : g_lo
                assign sensor_byte[g] = state.accel_out[g/2][7:0];
            end else begin : g_oth
                assign sensor_byte[g] = other_sensor_bytes_i[(g-ACCEL_BYTES)*8 +: 8];
            end
        end
    endgenerate

    // ==========================================================
    // source flag lookup
    // which source-enable flag governs a given sensor byte
    function automatic logic [2:0] byte_source_bit(input logic [3:0] idx);
        logic [2:0] pair;
        pair = idx[3:1];
        if (idx < 4'(ACCEL_BYTES)) begin
            byte_source_bit = ACCEL_EN_BIT;
        end else begin
            unique case (pair)
                3'h3:    byte_source_bit = TEMP_EN_BIT;
                3'h4:    byte_source_bit = GYRO_X_EN_BIT;
                3'h5:    byte_source_bit = GYRO_Y_EN_BIT;
                default: byte_source_bit = GYRO_Z_EN_BIT;
            endcase
        end
    endfunction

    // ==========================================================
    // access qualification
    logic       access_ok;
    logic       do_write;
    logic       do_read;
    logic       host_push;
    logic       host_pop;
    logic       load_push;
    logic       push;
    logic       queue_full;
    logic       queue_empty;
    logic [7:0] push_byte;
    logic [7:0] load_byte;
    logic       load_byte_on;

    // an I2C access only counts when the target is on and addressed
    assign i2c_target_addr_o = I2C_TARGET_BASE | {6'h00, address_select_pin_i};
    assign access_ok = !via_i2c_i ||
                       (!state.target_disable && i2c_target_addr_i == i2c_target_addr_o);
    assign do_write  = reg_write_i && access_ok;
    assign do_read   = reg_read_i && access_ok;

    // full at DEPTH; DEPTH must stay below 65536 for the 16-bit count
    assign queue_full  = (state.count == COUNT_BITS'(DEPTH));
    assign queue_empty = (state.count == '0);

    // data port traffic only while the queue is enabled
    assign host_push = do_write && reg_addr_i == QUEUE_DATA_WINDOW && queue_enable_i;
    assign host_pop  = do_read && reg_addr_i == QUEUE_DATA_WINDOW && queue_enable_i
                       && !queue_empty;

    // loader yields the write slot to the host for one cycle
    assign load_byte    = sensor_byte[state.load_idx];
    assign load_byte_on = queue_source_enable_i[byte_source_bit(state.load_idx)];
    assign load_push    = state.load_state == LOAD_SCAN && !host_push && load_byte_on
                          && queue_enable_i;
    assign push         = host_push || load_push;
    // 0xff is kept free as the empty marker
    assign push_byte    = host_push ? reg_wdata_i : load_byte;

    // wrap by compare so a depth that is not a power of two works
    function automatic logic [PTR_BITS-1:0] ptr_inc(input logic [PTR_BITS-1:0] p);
        ptr_inc = (p == PTR_BITS'(DEPTH - 1)) ? '0 : p + PTR_BITS'(1);
    endfunction

    // ==========================================================
    // next-state logic
    always_comb begin
        next_state           = state;
        next_state.overrun   = 1'b0;
        next_state.accel_out = accel_fixed;

        // register writes
        if (do_write) begin
            unique case (reg_addr_i)
                SERIAL_INTERFACE_SELECT:
                    next_state.target_disable = reg_wdata_i[SERIAL_TARGET_DISABLE_BIT];
                X_ACCEL_OFFSET_UPPER: next_state.offset[0][OFFSET_BITS-1:OFFSET_LOW_BITS] = reg_wdata_i;
                X_ACCEL_OFFSET_LOWER: next_state.offset[0][OFFSET_LOW_BITS-1:0] = reg_wdata_i[7:1];
                Y_ACCEL_OFFSET_UPPER: next_state.offset[1][OFFSET_BITS-1:OFFSET_LOW_BITS] = reg_wdata_i;
                Y_ACCEL_OFFSET_LOWER: next_state.offset[1][OFFSET_LOW_BITS-1:0] = reg_wdata_i[7:1];
                Z_ACCEL_OFFSET_UPPER: next_state.offset[2][OFFSET_BITS-1:OFFSET_LOW_BITS] = reg_wdata_i;
                Z_ACCEL_OFFSET_LOWER: next_state.offset[2][OFFSET_LOW_BITS-1:0] = reg_wdata_i[7:1];
                default: ;
            endcase
        end

        // register reads, data held until the next read
        if (do_read) begin
            unique case (reg_addr_i)
                SERIAL_INTERFACE_SELECT: begin
                    next_state.rdata                            = 8'h00; // reserved bits read as zero
                    next_state.rdata[SERIAL_TARGET_DISABLE_BIT] = state.target_disable;
                end
                QUEUE_LEVEL_HIGH: begin
                    next_state.rdata      = state.count[15:8];
                    next_state.held_count = state.count;
                end
                QUEUE_LEVEL_LOW: begin
                    next_state.rdata      = state.held_count[7:0];
                    next_state.held_count = state.count;
                end
                QUEUE_DATA_WINDOW:
                    next_state.rdata = host_pop ? state.mem[state.rd_ptr] : QUEUE_EMPTY_MARK;
                PART_IDENTITY:        next_state.rdata = IDENTITY_CODE;
                X_ACCEL_OFFSET_UPPER: next_state.rdata = state.offset[0][OFFSET_BITS-1:OFFSET_LOW_BITS];
                X_ACCEL_OFFSET_LOWER: next_state.rdata = {state.offset[0][OFFSET_LOW_BITS-1:0], 1'b0};
                Y_ACCEL_OFFSET_UPPER: next_state.rdata = state.offset[1][OFFSET_BITS-1:OFFSET_LOW_BITS];
                Y_ACCEL_OFFSET_LOWER: next_state.rdata = {state.offset[1][OFFSET_LOW_BITS-1:0], 1'b0};
                Z_ACCEL_OFFSET_UPPER: next_state.rdata = state.offset[2][OFFSET_BITS-1:OFFSET_LOW_BITS];
                Z_ACCEL_OFFSET_LOWER: next_state.rdata = {state.offset[2][OFFSET_LOW_BITS-1:0], 1'b0};
                default:              next_state.rdata = 8'h00;
            endcase
        end

        // sample loader walks bytes 0..13 after a tick taken while idle
        unique case (state.load_state)
            LOAD_IDLE: begin
                if (sample_tick_i && queue_enable_i) begin
                    next_state.load_state = LOAD_SCAN;
                    next_state.load_idx   = '0;
                end
            end
            LOAD_SCAN: begin
                // a host write to the data port holds the scan on the same byte
                if (!host_push) begin
                    if (state.load_idx == BYTE_IDX_BITS'(SENSOR_BYTES - 1)) begin
                        next_state.load_state = LOAD_IDLE;
                    end else begin
                        next_state.load_idx = state.load_idx + BYTE_IDX_BITS'(1);
                    end
                end
            end
            default: next_state.load_state = LOAD_IDLE;
        endcase

        // queue bookkeeping
        if (host_pop) begin
            next_state.rd_ptr = ptr_inc(state.rd_ptr);
        end
        // a push into a full queue evicts the oldest byte or is dropped
        if (push) begin
            if (queue_full && !host_pop) begin
                next_state.overrun = 1'b1;
                if (!stop_when_full_i) begin
                    // drop oldest byte to make room for the new one
                    next_state.mem[state.wr_ptr] = (push_byte == QUEUE_EMPTY_MARK) ?
                                                   QUEUE_DATA_CLAMP : push_byte;
                    next_state.wr_ptr = ptr_inc(state.wr_ptr);
                    next_state.rd_ptr = ptr_inc(state.rd_ptr);
                end
            end else begin
                next_state.mem[state.wr_ptr] = (push_byte == QUEUE_EMPTY_MARK) ?
                                               QUEUE_DATA_CLAMP : push_byte;
                next_state.wr_ptr = ptr_inc(state.wr_ptr);
                if (!host_pop) begin
                    next_state.count = state.count + COUNT_BITS'(1);
                end
            end
        end else if (host_pop) begin
            next_state.count = state.count - COUNT_BITS'(1);
        end

        // queue reset wins over any traffic in the same cycle
        if (queue_reset_i) begin
            next_state.wr_ptr     = '0;
            next_state.rd_ptr     = '0;
            next_state.count      = '0;
            next_state.load_state = LOAD_IDLE;
            next_state.load_idx   = '0;
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state            <= '0;
            // the idle code is not all zeros
            state.load_state <= LOAD_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // outputs
    assign reg_rdata_o             = state.rdata;
    assign serial_target_disable_o = state.target_disable;
    assign accel_corrected_o       = state.accel_out;
    assign queue_overrun_flag_o    = state.overrun;

endmodule

// [sensor_queue_regs_properties.sv]
module sensor_queue_props
    import sensor_queue_pkg::*;
#(
    parameter logic [7:0] IDENTITY_CODE = 8'h5a  // arbitrary value
) (
    input wire logic       clk_i,
    input wire logic       reset_i,
    input wire logic       reg_write_i,
    input wire logic       reg_read_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       via_i2c_i,
    input wire logic       address_select_pin_i,
    input wire logic       queue_enable_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       serial_target_disable_o,
    input wire logic [6:0] i2c_target_addr_o,
    input wire logic       queue_overrun_flag_o
);
    // ==========================================================
    // accepted accesses over the spi path
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence spi_rd(logic [6:0] a);
        reg_read_i && !via_i2c_i && reg_addr_i == a;
    endsequence
    sequence spi_wr(logic [6:0] a);
        reg_write_i && !via_i2c_i && reg_addr_i == a;
    endsequence

    // ==========================================================
    // register behaviour
    AST_IDENTITY: assert property (spi_rd(PART_IDENTITY) |=> reg_rdata_o == IDENTITY_CODE)
        else $error("identity read gave wrong value");
    AST_TARGET_OFF: assert property (spi_wr(SERIAL_INTERFACE_SELECT) |=>
        serial_target_disable_o == $past(reg_wdata_i[6])) else $error("target disable bit not applied");
    AST_I2C_REFUSED: assert property (serial_target_disable_o && reg_read_i && via_i2c_i |=>
        $stable(reg_rdata_o)) else $error("i2c read answered while disabled");
    AST_OFFSET_BIT0: assert property ((spi_rd(X_ACCEL_OFFSET_LOWER) or spi_rd(Y_ACCEL_OFFSET_LOWER)
        or spi_rd(Z_ACCEL_OFFSET_LOWER)) |=> !reg_rdata_o[0]) else $error("offset reserved bit set");
    AST_QUEUE_OFF: assert property (spi_rd(QUEUE_DATA_WINDOW) ##0 !queue_enable_i |=>
        reg_rdata_o == QUEUE_EMPTY_MARK) else $error("disabled queue read not empty mark");
    AST_RDATA_HOLD: assert property (!reg_read_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    AST_TARGET_ADDR: assert property (i2c_target_addr_o == {I2C_TARGET_BASE[6:1], address_select_pin_i})
        else $error("target address wrong");
    AST_OVERRUN_EN: assert property (queue_overrun_flag_o |-> $past(queue_enable_i))
        else $error("overrun flagged with queue disabled");
    AST_SELECT_RESERVED: assert property (spi_rd(SERIAL_INTERFACE_SELECT) |=>
        reg_rdata_o[7] == 1'b0 && reg_rdata_o[5:0] == 6'h00) else $error("select reserved bits not zero");
endmodule

bind sensor_queue_regs sensor_queue_props #(.IDENTITY_CODE(IDENTITY_CODE)) i_sensor_queue_props (
    .clk_i(clk_i), .reset_i(reset_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .via_i2c_i(via_i2c_i),
    .address_select_pin_i(address_select_pin_i), .queue_enable_i(queue_enable_i),
    .reg_rdata_o(reg_rdata_o), .serial_target_disable_o(serial_target_disable_o),
    .i2c_target_addr_o(i2c_target_addr_o), .queue_overrun_flag_o(queue_overrun_flag_o)
);

// [sensor_host_model.sv]
module sensor_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] reg_rdata_i,
    output logic            reg_write_o,
    output logic            reg_read_o,
    output logic      [6:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            via_i2c_o,
    output logic      [6:0] i2c_target_addr_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // idle bus at time zero
    initial begin
        reg_write_o = 1'b0;
        reg_read_o = 1'b0;
        reg_addr_o = 7'h00;
        reg_wdata_o = 8'h00;
        via_i2c_o = 1'b0;
        i2c_target_addr_o = 7'h68;
    end
    // one byte access: strobe for one cycle, answer the edge after
    task automatic access(input logic wr, input logic [6:0] a, input logic [7:0] d,
                          input logic i2c, output logic [7:0] q);
        @(posedge clk_i);
        #1;
        reg_write_o = wr;
        reg_read_o = !wr;
        reg_addr_o = a;
        reg_wdata_o = d;
        via_i2c_o = i2c;
        @(posedge clk_i);
        #1;
        q = reg_rdata_i;
        reg_write_o = 1'b0;
        reg_read_o = 1'b0;
        reg_addr_o = ~a;  // released lines carry junk, not the old value
        reg_wdata_o = ~d;
    endtask
endmodule

// [tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import sensor_queue_pkg::*;
    localparam logic [7:0] ID_CODE = 8'h3c;  // arbitrary value
    logic        clk_i = 1'b0, reset = 1'b1, pin = 1'b0, tick = 1'b0, qen = 1'b1, qrst = 1'b0, stop = 1'b0;
    logic [7:0]  src = 8'h88, rdata;
    logic [1:0]  fs = 2'h0;
    logic [47:0] raw = 48'h0123_4567_1a2b, corr;
    logic [63:0] other = 64'h0807_0605_0403_0201;
    logic        wr_s, rd_s, via, dis, ovr;
    logic [6:0]  addr, taddr, own_addr;
    logic [7:0]  wdata;
    int          mismatches = 0, tests_run = 0, cycles = 0, overruns = 0;

    always #5 clk_i = ~clk_i;
    sensor_host_model i_sensor_host_model (.clk_i(clk_i), .reg_rdata_i(rdata), .reg_write_o(wr_s),
        .reg_read_o(rd_s), .reg_addr_o(addr), .reg_wdata_o(wdata), .via_i2c_o(via), .i2c_target_addr_o(taddr));
    sensor_queue_regs #(.DEPTH(8), .IDENTITY_CODE(ID_CODE)) i_sensor_queue_regs (.clk_i(clk_i),
        .reset_i(reset), .reg_write_i(wr_s), .reg_read_i(rd_s), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .via_i2c_i(via), .i2c_target_addr_i(taddr), .address_select_pin_i(pin), .sample_tick_i(tick),
        .queue_source_enable_i(src), .queue_enable_i(qen), .queue_reset_i(qrst), .stop_when_full_i(stop),
        .accel_full_scale_i(fs), .accel_raw_i(raw), .other_sensor_bytes_i(other), .reg_rdata_o(rdata),
        .serial_target_disable_o(dis), .i2c_target_addr_o(own_addr), .accel_corrected_o(corr),
        .queue_overrun_flag_o(ovr));

    // ==========================================================
    // watchdog and overrun pulse counter
    always @(posedge clk_i) begin
        cycles++;
        if (ovr === 1'b1) overruns++;
        if (cycles == 5000) begin
            mismatches++;
            results;
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        i_sensor_host_model.access(1'b1, a, d, 1'b0, q);
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e, input logic i2c = 1'b0);
        logic [7:0] q;
        i_sensor_host_model.access(1'b0, a, 8'h00, i2c, q);
        check(q, e);
    endtask
    task automatic pulse(ref logic s);
        @(posedge clk_i);
        #1 s = 1'b1;
        @(posedge clk_i);
        #1 s = 1'b0;
    endtask

    // ==========================================================
    // scenarios
    task automatic test_loader;
        pulse(tick);
        repeat (20) @(posedge clk_i);  // scan is 14 cycles, no stalls
        rd_chk(QUEUE_LEVEL_HIGH, 8'h00);
        rd_chk(QUEUE_LEVEL_LOW, 8'h08);
        for (int i = 0; i < 8; i++) begin
            rd_chk(QUEUE_DATA_WINDOW, (i < 6) ? raw[(i/2)*16 + ((i%2) ? 0 : 8) +: 8] : other[(i-6)*8 +: 8]);
        end
        $display("test loader done");
    endtask
    task automatic test_ident;
        rd_chk(PART_IDENTITY, ID_CODE);
        wr(PART_IDENTITY, 8'h00);
        rd_chk(PART_IDENTITY, ID_CODE);
        rd_chk(QUEUE_DATA_WINDOW, QUEUE_EMPTY_MARK);
        pin = 1'b1;
        #1 check({1'b0, own_addr}, 8'h69);
        @(posedge clk_i);
        #1 pin = 1'b0;
        #1 check({1'b0, own_addr}, 8'h68);
        $display("test ident done");
    endtask
    task automatic test_queue;
        wr(QUEUE_DATA_WINDOW, 8'ha1);
        wr(QUEUE_DATA_WINDOW, 8'hff);
        wr(QUEUE_DATA_WINDOW, 8'hb3);
        rd_chk(QUEUE_LEVEL_HIGH, 8'h00);
        rd_chk(QUEUE_LEVEL_LOW, 8'h03);
        rd_chk(QUEUE_DATA_WINDOW, 8'ha1);
        rd_chk(QUEUE_DATA_WINDOW, 8'hfe);
        rd_chk(QUEUE_DATA_WINDOW, 8'hb3);
        rd_chk(QUEUE_LEVEL_LOW, 8'h03);
        rd_chk(QUEUE_LEVEL_LOW, 8'h00);
        rd_chk(QUEUE_DATA_WINDOW, QUEUE_EMPTY_MARK);
        $display("test queue done");
    endtask
    task automatic test_overflow;
        for (int i = 1; i <= 9; i++) wr(QUEUE_DATA_WINDOW, 8'(i));
        rd_chk(QUEUE_LEVEL_HIGH, 8'h00);
        rd_chk(QUEUE_LEVEL_LOW, 8'h08);
        check(8'(overruns), 8'h01);
        rd_chk(QUEUE_DATA_WINDOW, 8'h02);
        pulse(qrst);
        rd_chk(QUEUE_DATA_WINDOW, QUEUE_EMPTY_MARK);
        stop = 1'b1;
        for (int i = 1; i <= 9; i++) wr(QUEUE_DATA_WINDOW, 8'h10 + 8'(i));
        rd_chk(QUEUE_DATA_WINDOW, 8'h11);
        check(8'(overruns), 8'h02);
        stop = 1'b0;
        pulse(qrst);
        $display("test overflow done");
    endtask
    task automatic test_disable;
        qen = 1'b0;
        wr(QUEUE_DATA_WINDOW, 8'h55);
        rd_chk(QUEUE_DATA_WINDOW, QUEUE_EMPTY_MARK);
        qen = 1'b1;
        rd_chk(QUEUE_DATA_WINDOW, QUEUE_EMPTY_MARK);
        rd_chk(PART_IDENTITY, ID_CODE, 1'b1);
        wr(SERIAL_INTERFACE_SELECT, 8'h40);
        check({7'h00, dis}, 8'h01);
        rd_chk(QUEUE_LEVEL_HIGH, ID_CODE, 1'b1);
        rd_chk(SERIAL_INTERFACE_SELECT, 8'h40);
        wr(SERIAL_INTERFACE_SELECT, 8'h00);
        check({7'h00, dis}, 8'h00);
        $display("test disable done");
    endtask
    task automatic test_offset;
        for (int i = 0; i < 3; i++) begin
            wr(X_ACCEL_OFFSET_UPPER + 7'(3*i), 8'ha5 + 8'(i));
            wr(X_ACCEL_OFFSET_LOWER + 7'(3*i), 8'hff);
            rd_chk(X_ACCEL_OFFSET_UPPER + 7'(3*i), 8'ha5 + 8'(i));
            rd_chk(X_ACCEL_OFFSET_LOWER + 7'(3*i), 8'hfe);
        end
        wr(X_ACCEL_OFFSET_UPPER, 8'h00);
        wr(X_ACCEL_OFFSET_LOWER, 8'h02);
        repeat (3) @(posedge clk_i);
        #1 check(corr[7:0], 8'h1b);
        fs = 2'h3;
        repeat (3) @(posedge clk_i);
        #1 check(corr[7:0], 8'h29);
        $display("test offset done");
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (6) @(posedge clk_i);
        #1 reset = 1'b0;
        test_loader;
        test_ident;
        test_queue;
        test_overflow;
        test_disable;
        test_offset;
        results;
    end
endmodule
